// ---- inc/xxtfc_pkg.sv ----
/*
  Constants and carrier types for the in-band pause/resume flow control
  on the transmit side of an asynchronous serial port.
  Assumes character framing and bit timing are handled by the surrounding
  receiver and transmitter on the same system clock.
*/
package xxtfc_pkg;

  // ----------------------------------------------------------------
  // Character widths
  // ----------------------------------------------------------------
  localparam int CHAR_W = 8;
  localparam int CODE_W = 7;

  // ----------------------------------------------------------------
  // Handshake codes, 7-bit
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] RESUME_CODE = 7'h11;
  localparam logic [CODE_W-1:0] PAUSE_CODE = 7'h13;

  // ----------------------------------------------------------------
  // Buffer and status sizing
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // Reset values and counter step and limit
  // ----------------------------------------------------------------
  localparam logic [CHAR_W-1:0] CHAR_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [CHAR_W-1:0] data;
  } xxtfc_char_t;

  typedef enum logic [1:0] {
    XXTFC_RUN = 2'b00,
    XXTFC_HALT = 2'b01
  } xxtfc_state_t;

endpackage

// ---- rtl/xxtfc_fifo.sv ----
/*
  Synchronous FIFO with valid/ready on both sides, width and depth set by
  parameters. Flags come from registers so that ready and valid are glitch
  free toward both neighbours.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module xxtfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW-1:0] PTR_ZERO = '0;
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
  localparam logic [AW:0] CNT_ZERO = '0;
  localparam logic [AW:0] CNT_ONE = (AW + 1)'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic [AW:0] nxt_count;
  logic in_ready_ff;
  logic empty_ff;
  logic push;
  logic pop;

  assign push = in_valid & in_ready_ff;
  assign pop = out_ready & ~empty_ff;
  // Ready is its own register so the port comes straight from a flop
  assign in_ready = in_ready_ff;
  assign out_valid = ~empty_ff;
  assign out_data = mem[rd_ptr_ff];

  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + CNT_ONE;
    end else if (pop && !push) begin
      nxt_count = count_ff - CNT_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr_ff <= PTR_ZERO;
      rd_ptr_ff <= PTR_ZERO;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? PTR_ZERO : wr_ptr_ff + AW'(1);
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PTR_LAST) ? PTR_ZERO : rd_ptr_ff + AW'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      count_ff <= CNT_ZERO;
      in_ready_ff <= 1'b1;
      empty_ff <= 1'b1;
    end else begin
      count_ff <= nxt_count;
      in_ready_ff <= (nxt_count != CNT_FULL);
      empty_ff <= (nxt_count == CNT_ZERO);
    end
  end

endmodule

// ---- rtl/xxtfc_top.sv ----
/*
  Transmit-side software flow control. Outgoing characters are buffered,
  then handed one at a time to the serial transmitter; received characters
  are watched for the pause and resume codes, which gate the hand-over.
  Assumes the receiver delivers whole characters as one-cycle strobes and
  the transmitter takes a character into its shifter on valid and ready,
  both on this clock.
*/
`timescale 1ns/100ps
module xxtfc_top
  import xxtfc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter bit FILTER_CODES = 1'b1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic flow_en,
  input wire logic [CHAR_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  input xxtfc_char_t rx_char,
  output xxtfc_char_t rx_out,
  output logic [CHAR_W-1:0] tx_char_data,
  output logic tx_char_valid,
  input wire logic tx_char_ready,
  input wire logic tx_busy,
  output logic halted,
  output logic line_quiet,
  output logic stray_resume,
  output logic [CNT_W-1:0] pause_cnt,
  output logic [CNT_W-1:0] stray_cnt
);

  // ----------------------------------------------------------------
  // Outgoing buffer
  // ----------------------------------------------------------------
  logic [CHAR_W-1:0] f_data;
  logic f_valid;
  logic f_ready;

  xxtfc_fifo #(
    .WIDTH(CHAR_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock(clock),
    .srst(srst),
    .in_data(in_data),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );

  // ----------------------------------------------------------------
  // Handshake code recognition
  // ----------------------------------------------------------------
  logic is_resume;
  logic is_pause;

  // Parity or eighth bit is ignored; the codes are 7-bit
  assign is_resume = flow_en & rx_char.valid
                     & (rx_char.data[CODE_W-1:0] == RESUME_CODE);
  assign is_pause = flow_en & rx_char.valid
                    & (rx_char.data[CODE_W-1:0] == PAUSE_CODE);

  // ----------------------------------------------------------------
  // Pause/resume state
  // ----------------------------------------------------------------
  xxtfc_state_t state_ff;
  xxtfc_state_t nxt_state;
  logic nxt_halted;
  logic stray;

  always_comb begin
    nxt_state = state_ff;
    stray = 1'b0;
    case (state_ff)
      XXTFC_RUN: begin
        if (is_pause) begin
          nxt_state = XXTFC_HALT;
        end else if (is_resume) begin
          stray = 1'b1;
        end
      end
      XXTFC_HALT: begin
        if (is_resume) begin
          nxt_state = XXTFC_RUN;
        end
      end
      default: begin
        nxt_state = XXTFC_RUN;
      end
    endcase
    // Dropping flow control must never leave the sender stuck
    if (!flow_en) begin
      nxt_state = XXTFC_RUN;
    end
  end

  assign nxt_halted = (nxt_state == XXTFC_HALT);

  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= XXTFC_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Character hand-over to the transmitter
  // ----------------------------------------------------------------
  // One character is held here between the buffer and the shifter. While
  // halted it stays held and is offered again on resume, so the stream
  // picks up exactly where it stopped.
  logic pend_ff;
  logic tx_valid_ff;
  logic [CHAR_W-1:0] tx_data_ff;
  logic xfer;
  logic load;
  logic nxt_pend;

  // A character taken in the same cycle as the pause is already committed
  assign xfer = tx_valid_ff & tx_char_ready;
  assign load = f_valid & (~pend_ff | xfer);
  assign f_ready = ~pend_ff | xfer;
  assign nxt_pend = load | (pend_ff & ~xfer);

  always_ff @(posedge clock) begin
    if (srst) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tx_data_ff <= CHAR_RST;
    end else if (load) begin
      tx_data_ff <= f_data;
    end
  end

  // Offer is withdrawn while halted; the held character is not lost
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_valid_ff <= 1'b0;
    end else begin
      tx_valid_ff <= nxt_pend & ~nxt_halted;
    end
  end

  assign tx_char_data = tx_data_ff;
  assign tx_char_valid = tx_valid_ff;

  // ----------------------------------------------------------------
  // Received data passed on
  // ----------------------------------------------------------------
  logic drop_code;

  assign drop_code = FILTER_CODES & (is_pause | is_resume);

  always_ff @(posedge clock) begin
    if (srst) begin
      rx_out <= '{valid: 1'b0, data: CHAR_RST};
    end else begin
      rx_out.valid <= rx_char.valid & ~drop_code;
      if (rx_char.valid) begin
        rx_out.data <= rx_char.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  logic halted_ff;
  logic line_quiet_ff;
  logic stray_ff;
  logic [CNT_W-1:0] pause_cnt_ff;
  logic [CNT_W-1:0] stray_cnt_ff;

  always_ff @(posedge clock) begin
    if (srst) begin
      halted_ff <= 1'b0;
      stray_ff <= 1'b0;
    end else begin
      halted_ff <= nxt_halted;
      stray_ff <= stray;
    end
  end

  // Quiet means halted and the shifter has drained its last character
  always_ff @(posedge clock) begin
    if (srst) begin
      line_quiet_ff <= 1'b0;
    end else begin
      line_quiet_ff <= nxt_halted & ~tx_busy & ~xfer;
    end
  end

  // Counters saturate rather than wrap, so a busy link never reads low
  always_ff @(posedge clock) begin
    if (srst) begin
      pause_cnt_ff <= CNT_RST;
    end else if (is_pause && state_ff == XXTFC_RUN && pause_cnt_ff != CNT_MAX) begin
      pause_cnt_ff <= pause_cnt_ff + CNT_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      stray_cnt_ff <= CNT_RST;
    end else if (stray && stray_cnt_ff != CNT_MAX) begin
      stray_cnt_ff <= stray_cnt_ff + CNT_ONE;
    end
  end

  assign halted = halted_ff;
  assign line_quiet = line_quiet_ff;
  assign stray_resume = stray_ff;
  assign pause_cnt = pause_cnt_ff;
  assign stray_cnt = stray_cnt_ff;

endmodule

// ---- test/xxtfc_properties.sv ----
/* Port assertions for xxtfc_top.
   Assumes one clock and the synchronous reset srst. */
`timescale 1ns/100ps
module xxtfc_properties
  import xxtfc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic flow_en,
  input xxtfc_char_t rx_char,
  input wire logic [CHAR_W-1:0] tx_char_data,
  input wire logic tx_char_valid,
  input wire logic tx_char_ready,
  input wire logic tx_busy,
  input wire logic halted,
  input wire logic line_quiet,
  input wire logic stray_resume
);
  // ----
  // Code strobes, low 7 bits only
  // ----
  logic pz;
  logic rz;
  assign pz = rx_char.valid && flow_en && rx_char.data[CODE_W-1:0] == PAUSE_CODE;
  assign rz = rx_char.valid && flow_en && rx_char.data[CODE_W-1:0] == RESUME_CODE;
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);
  property p_pause;
    pz |=> halted && !tx_char_valid;
  endproperty
  a_pause: assert property (p_pause) else $error("pause ignored");
  property p_resume;
    halted && rz |=> !halted;
  endproperty
  a_resume: assert property (p_resume) else $error("resume ignored");
  property p_stray;
    !halted && rz |=> stray_resume && !halted;
  endproperty
  a_stray: assert property (p_stray) else $error("stray resume acted on");
  property p_refuse;
    halted |-> !tx_char_valid;
  endproperty
  a_refuse: assert property (p_refuse) else $error("offer while halted");
  property p_off;
    !flow_en |=> !halted;
  endproperty
  a_off: assert property (p_off) else $error("halted with flow off");
  property p_hold;
    tx_char_valid && !tx_char_ready && !pz |=> tx_char_valid && $stable(tx_char_data);
  endproperty
  a_hold: assert property (p_hold) else $error("offer changed");
  property p_quiet;
    line_quiet |-> halted && !$past(tx_busy);
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet while shifting");
endmodule
bind xxtfc_top xxtfc_properties u_props (.clock, .srst, .flow_en, .rx_char, .tx_char_data,
  .tx_char_valid, .tx_char_ready, .tx_busy, .halted, .line_quiet, .stray_resume);

// ---- test/xxtfc_remote.sv ----
/* Remote serial party: takes characters, shifts them, sends pause/resume.
   Assumes the bench supplies random bits and injected characters. */
`timescale 1ns/100ps
module xxtfc_remote
  import xxtfc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic auto_en,
  input wire logic [2:0] jitter,
  input xxtfc_char_t inj,
  input wire logic [CHAR_W-1:0] tx_char_data,
  input wire logic tx_char_valid,
  output logic tx_char_ready,
  output logic tx_busy,
  output xxtfc_char_t rx_char
);
  logic [1:0] shift_ff;
  logic [2:0] fill_ff;
  logic paused_ff;
  logic took;
  assign took = tx_char_valid && tx_char_ready;
  always @(posedge clock) begin
    if (srst) begin
      {tx_char_ready, tx_busy, shift_ff, fill_ff, paused_ff} <= '0;
      rx_char <= '0;
    end else begin
      shift_ff <= took ? 2'h3 : shift_ff - {1'b0, shift_ff != 2'h0};
      tx_busy <= took || shift_ff > 2'h1;
      tx_char_ready <= !took && shift_ff <= 2'h1 && !jitter[0];
      // Slow drain so the backlog really builds up
      if (took)
        fill_ff <= fill_ff + 3'h1;
      else if (&jitter && fill_ff != 3'h0)
        fill_ff <= fill_ff - 3'h1;
      rx_char <= {1'b0, ~rx_char.data};
      if (inj.valid) begin
        rx_char <= inj;
      end else if (auto_en && !paused_ff && fill_ff >= 3'h4) begin
        rx_char <= {1'b1, 8'h13};
        paused_ff <= 1'b1;
      end else if (auto_en && paused_ff && fill_ff == 3'h0) begin
        rx_char <= {1'b1, 8'h11};
        paused_ff <= 1'b0;
      end
    end
  end
endmodule

// ---- test/xxtfc_top_tb.sv ----
/* Self-checking bench for xxtfc_top with the remote model.
   Assumes the checker is bound through its own file. */
`timescale 1ns/100ps
module xxtfc_top_tb;
  import xxtfc_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic flow_en = 1'b1;
  logic [CHAR_W-1:0] in_data = 8'h00;
  logic in_valid = 1'b0;
  logic auto_en = 1'b0;
  logic [2:0] jitter = 3'h0;
  xxtfc_char_t inj = '0;
  xxtfc_char_t rx_char, rx_out;
  logic [CHAR_W-1:0] tx_char_data;
  logic in_ready, tx_char_valid, tx_char_ready, tx_busy, halted;
  logic line_quiet, stray_resume;
  int stray_pulses = 0;
  logic [CNT_W-1:0] pause_cnt, stray_cnt, s;
  logic [31:0] seed = 32'h105cdd68;
  int fail_count = 0;
  int num_checks = 0;
  int n;
  logic [CHAR_W-1:0] txq[$];
  logic [CHAR_W:0] rxq[$];
  always #4 clock = ~clock;
  xxtfc_top dut (.clock, .srst, .flow_en, .in_data, .in_valid, .in_ready, .rx_char, .rx_out,
    .tx_char_data, .tx_char_valid, .tx_char_ready, .tx_busy, .halted, .line_quiet,
    .stray_resume, .pause_cnt, .stray_cnt);
  xxtfc_remote u_remote (.clock, .srst, .auto_en, .jitter, .inj, .tx_char_data,
    .tx_char_valid, .tx_char_ready, .tx_busy, .rx_char);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----
  // Drivers, all on the falling edge
  // ----
  always @(negedge clock) begin
    seed <= lfsr(seed);
    jitter <= seed[2:0];
  end
  task automatic push(input int want, input int lim, output int cnt);
    cnt = 0;
    in_valid = 1'b1;
    for (int t = 0; t < lim && cnt < want; t++) begin
      if (in_ready === 1'b1) begin
        in_data = seed[15:8];
        txq.push_back(in_data);
        cnt++;
      end
      @(negedge clock);
    end
    in_valid = 1'b0;
  endtask
  task automatic inject(input logic [7:0] d);
    inj = {1'b1, d};
    @(negedge clock);
    inj = '0;
    repeat (4) @(negedge clock);
  endtask
  task automatic drain;
    int t;
    t = 0;
    while ((txq.size() != 0 || halted !== 1'b0 || tx_busy !== 1'b0 || tx_char_valid !== 1'b0)
           && t < 5000) begin
      @(negedge clock);
      t++;
    end
    if (t == 5000) begin
      fail_count++;
      $display("Error at %0t: drain timed out", $time);
      end_sim;
    end
  endtask
  // ----
  // Scoreboards: stream order and passed-on received characters
  // ----
  // Sampled mid-cycle: what stands now is what the next rising edge takes
  always @(negedge clock) begin
    if (!srst && stray_resume === 1'b1)
      stray_pulses++;
    if (!srst && tx_char_valid && tx_char_ready)
      chk({8'h00, tx_char_data}, txq.size() ? {8'h00, txq.pop_front()} : 16'hffff);
    if (!srst && rx_out.valid)
      chk({7'h00, rx_out}, rxq.size() ? {7'h00, rxq.pop_front()} : 16'hffff);
  end
  initial begin
    repeat (10) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    auto_en = 1'b1;
    push(40, 2000, n);
    chk(n[15:0], 16'd40);
    drain;
    chk({15'h0, pause_cnt == 16'h0}, 16'h0);
    $display("test stream with remote pausing done");
    auto_en = 1'b0;
    s = stray_cnt;
    n = stray_pulses;
    inject(8'h91);
    chk(stray_cnt, s + 16'h1);
    chk(16'(stray_pulses - n), 16'h1);
    chk({15'h0, halted}, 16'h0);
    $display("test stray resume done");
    inject(8'h93);
    chk({15'h0, halted}, 16'h1);
    chk({15'h0, line_quiet}, 16'h1);
    push(100, 40, n);
    chk(n[15:0], 16'(FIFO_DEPTH + 1));
    chk({15'h0, line_quiet}, 16'h1);
    inject(8'h11);
    chk({15'h0, halted}, 16'h0);
    chk({15'h0, line_quiet}, 16'h0);
    drain;
    $display("test halt fill and resume done");
    flow_en = 1'b0;
    rxq.push_back({1'b1, 8'h13});
    inject(8'h13);
    chk({15'h0, halted}, 16'h0);
    flow_en = 1'b1;
    rxq.push_back({1'b1, 8'h41});
    inject(8'h41);
    chk(16'(rxq.size()), 16'h0);
    $display("test flow off and pass through done");
    end_sim;
  end
endmodule
